// ==== clkgen_consts.svh ====
// Constants for the clock generator mode controller
`ifndef CLKGEN_CONSTS_SVH
`define CLKGEN_CONSTS_SVH
`define SRC_FLL             2'h0
`define SRC_INTERNAL        2'h1
`define SRC_EXTERNAL        2'h2
`define SRC_RESERVED        2'h3
`define RST_REF_SELECT      1'h1
`define RST_SOURCE_SELECT   2'h0
`define RST_PLL_SELECT      1'h0
`define RST_DCO_RANGE       2'h0
`define REF_SWITCH_CYCLES   8'h04
`define SRC_SWITCH_CYCLES   8'h04
`define DCO_START_CYCLES    8'h10
`define LOCK_ACQ_CYCLES     8'h20
`endif

// ==== clkgen_lock_if.sv ====
// Lock timer request and status bundle
`default_nettype none
interface clkgen_lock_if;
  logic       restart;
  logic [7:0] length;
  logic       running;
  modport ctrl  (output restart, output length, input running);
  modport timer (input restart, input length, output running);
endinterface
`default_nettype wire

// ==== clkgen_lock_timer.sv ====
// Down counter that models loop lock acquisition
`default_nettype none
module clkgen_lock_timer (
  input  wire logic  i_sys_clk,
  input  wire logic  i_rstn,
  input  wire logic  i_ref_tick,
  clkgen_lock_if.timer lk
);
  logic [7:0] count_r;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_r <= 8'h00;
    end else if (lk.restart) begin
      count_r <= lk.length;
    end else if (i_ref_tick && count_r != 8'h00) begin
      count_r <= count_r - 8'h01;
    end
  end
  assign lk.running = (count_r != 8'h00);
endmodule
`default_nettype wire

// ==== clkgen_mode_ctrl.sv ====
// Mode selection and switching logic of the clock generator
// Notes on behaviour
// - External, source 00, pll select: PLL output
// - External, source 10, PLL runs for lock
// - PLL modes: debug clock from oscillator, else FLL off
// - Range status reads zero in PLL/low-power modes
// - Internal low-power bypass: internal ref, loops off
// - Debug enable moves internal low-power to FLL bypass
// - External low-power bypass: external ref, loops off
// - Debug enable moves external low-power to bypass
// - Stop disables loops, holds generated clocks static
// - Internal ref out in stop needs both enables
// - External ref out in stop needs enable, stop-enable
// - Reference status follows after switch completes
// - Engaged ref switch restarts loop lock
// - Source status follows after new clock takes over
// - Unavailable source keeps previous source and status
// - Range select frozen while low-power bit set
// - Engaged range change waits for new oscillator
// - Unlocked during startup, then lock and status
// - FLL bypassed internal: internal ref, source 01
// - Reset gives FLL engaged internal mode
// - External ref runs in stop with both enables
`default_nettype none
`include "clkgen_consts.svh"
module clkgen_mode_ctrl #(
  parameter int REF_TICK_DIV = 8
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_reference_select,
  input  wire logic [1:0] i_output_source_select,
  input  wire logic       i_pll_select,
  input  wire logic       i_loop_low_power,
  input  wire logic [1:0] i_dco_range_select,
  input  wire logic       i_debug_interface_enabled,
  input  wire logic       i_stop,
  input  wire logic       i_internal_ref_out_enable,
  input  wire logic       i_internal_ref_stop_enable,
  input  wire logic       i_external_ref_out_enable,
  input  wire logic       i_external_ref_stop_enable,
  input  wire logic       i_external_ref_ready,
  output logic            o_reference_status,
  output logic [1:0]      o_output_source_status,
  output logic [1:0]      o_dco_range_status,
  output logic            o_lock,
  output logic [3:0]      o_mode,
  output logic            o_fll_enable,
  output logic            o_pll_enable,
  output logic            o_main_from_pll,
  output logic            o_local_debug_clock_en,
  output logic            o_debug_clock_open_loop,
  output logic            o_internal_ref_clock_out_en,
  output logic            o_external_ref_clock_out_en,
  output logic            o_main_clock_gate
);
  clkgen_lock_if lk ();
  logic [$clog2(REF_TICK_DIV)-1:0] tick_cnt_r;
  logic                            ref_tick;
  logic                            ref_r;
  logic [1:0]                      src_r;
  logic                            pll_r;
  logic                            lp_r;
  logic [1:0]                      drs_r;
  logic [1:0]                      drs_done_r;
  logic [7:0]                      ref_cnt_r;
  logic [7:0]                      src_cnt_r;
  logic [7:0]                      dco_cnt_r;
  clkgen_pkg::mode_type            mode_r;
  clkgen_pkg::mode_type            mode_nxt;
  logic                            ref_switching;
  logic                            src_switching;
  logic                            lowpower;
  logic                            src_ok;
  logic                            allowed;
  logic                            ref_done;
  logic                            dco_done;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt_r <= '0;
    end else if (tick_cnt_r == ($clog2(REF_TICK_DIV))'(REF_TICK_DIV - 1)) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end
  assign ref_tick = (tick_cnt_r == '0);

  clkgen_lock_timer u_lock (
    .i_sys_clk  (i_sys_clk),
    .i_rstn     (i_rstn),
    .i_ref_tick (ref_tick),
    .lk         (lk)
  );

  assign lowpower = i_loop_low_power && !i_debug_interface_enabled;
  assign src_ok = (i_output_source_select != `SRC_RESERVED) &&
                  (i_output_source_select != `SRC_EXTERNAL || i_external_ref_ready);

  // Mode decode from the requested and settled fields
  always_comb begin
    mode_nxt = mode_r;
    if (ref_r) begin
      case (src_r)
        `SRC_FLL:      mode_nxt = clkgen_pkg::FLL_ENGAGED_INTERNAL;
        `SRC_INTERNAL: mode_nxt = lp_r ? clkgen_pkg::LOWPOWER_BYPASS_INTERNAL
                                       : clkgen_pkg::FLL_BYPASSED_INTERNAL;
        default:       mode_nxt = mode_r;
      endcase
    end else begin
      case (src_r)
        `SRC_FLL:      mode_nxt = pll_r ? clkgen_pkg::PLL_ENGAGED_EXTERNAL
                                        : clkgen_pkg::FLL_ENGAGED_EXTERNAL;
        `SRC_EXTERNAL: mode_nxt = lp_r ? clkgen_pkg::LOWPOWER_BYPASS_EXTERNAL
                                : pll_r ? clkgen_pkg::PLL_BYPASSED_EXTERNAL
                                        : clkgen_pkg::FLL_BYPASSED_EXTERNAL;
        default:       mode_nxt = mode_r;
      endcase
    end
  end

  // Permitted transitions; engaged PLL and FLL never swap directly
  always_comb begin
    allowed = 1'b1;
    case (mode_r)
      clkgen_pkg::FLL_ENGAGED_INTERNAL,
      clkgen_pkg::FLL_ENGAGED_EXTERNAL,
      clkgen_pkg::FLL_BYPASSED_INTERNAL,
      clkgen_pkg::FLL_BYPASSED_EXTERNAL:
        allowed = (mode_nxt != clkgen_pkg::PLL_ENGAGED_EXTERNAL);
      clkgen_pkg::PLL_ENGAGED_EXTERNAL:
        allowed = (mode_nxt == clkgen_pkg::PLL_BYPASSED_EXTERNAL);
      clkgen_pkg::PLL_BYPASSED_EXTERNAL:
        allowed = (mode_nxt == clkgen_pkg::PLL_ENGAGED_EXTERNAL) ||
                  (mode_nxt == clkgen_pkg::LOWPOWER_BYPASS_EXTERNAL) ||
                  (mode_nxt == clkgen_pkg::FLL_BYPASSED_EXTERNAL);
      clkgen_pkg::LOWPOWER_BYPASS_INTERNAL:
        allowed = (mode_nxt == clkgen_pkg::FLL_BYPASSED_INTERNAL);
      clkgen_pkg::LOWPOWER_BYPASS_EXTERNAL:
        allowed = (mode_nxt == clkgen_pkg::PLL_BYPASSED_EXTERNAL) ||
                  (mode_nxt == clkgen_pkg::FLL_BYPASSED_EXTERNAL);
      default:
        allowed = 1'b0;
    endcase
  end

  // Reference select switch with settle delay
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ref_r     <= `RST_REF_SELECT;
      ref_cnt_r <= 8'h00;
    end else if (i_reference_select != ref_r && ref_cnt_r == 8'h00) begin
      ref_cnt_r <= `REF_SWITCH_CYCLES;
    end else if (ref_cnt_r == 8'h01) begin
      ref_cnt_r <= 8'h00;
      ref_r     <= i_reference_select;
    end else if (ref_cnt_r != 8'h00) begin
      ref_cnt_r <= ref_cnt_r - 8'h01;
    end
  end
  assign ref_switching = (ref_cnt_r != 8'h00);
  assign ref_done = (ref_cnt_r == 8'h01) && (i_reference_select != ref_r);

  // Output source switch; unavailable source leaves old one
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      src_r     <= `RST_SOURCE_SELECT;
      src_cnt_r <= 8'h00;
    end else if (i_output_source_select != src_r && src_cnt_r == 8'h00) begin
      if (src_ok) begin
        src_cnt_r <= `SRC_SWITCH_CYCLES;
      end
    end else if (src_cnt_r == 8'h01) begin
      src_cnt_r <= 8'h00;
      if (src_ok) begin
        src_r <= i_output_source_select;
      end
    end else if (src_cnt_r != 8'h00) begin
      src_cnt_r <= src_cnt_r - 8'h01;
    end
  end
  assign src_switching = (src_cnt_r != 8'h00);

  // Loop select and low-power level follow immediately
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pll_r <= `RST_PLL_SELECT;
      lp_r  <= 1'b0;
    end else begin
      pll_r <= i_pll_select;
      lp_r  <= lowpower;
    end
  end

  // Mode register accepts only permitted moves
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_r <= clkgen_pkg::FLL_ENGAGED_INTERNAL;
    end else if (mode_nxt != mode_r && allowed) begin
      mode_r <= mode_nxt;
    end
  end

  // Range select, frozen under low power
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      drs_r      <= `RST_DCO_RANGE;
      drs_done_r <= `RST_DCO_RANGE;
      dco_cnt_r  <= 8'h00;
    end else begin
      if (!i_loop_low_power && i_dco_range_select != drs_r) begin
        drs_r     <= i_dco_range_select;
        dco_cnt_r <= `DCO_START_CYCLES;
      end else if (dco_cnt_r != 8'h00) begin
        dco_cnt_r <= dco_cnt_r - 8'h01;
      end
      if (dco_cnt_r == 8'h01) begin
        drs_done_r <= drs_r;
      end
    end
  end
  assign dco_done = (dco_cnt_r == 8'h01);

  // Relock after reference switch or new oscillator
  assign lk.restart = (ref_done && (mode_r == clkgen_pkg::FLL_ENGAGED_INTERNAL ||
                                    mode_r == clkgen_pkg::FLL_ENGAGED_EXTERNAL ||
                                    mode_r == clkgen_pkg::PLL_ENGAGED_EXTERNAL))
                      || dco_done || i_stop;
  assign lk.length = `LOCK_ACQ_CYCLES;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reference_status          <= `RST_REF_SELECT;
      o_output_source_status      <= `RST_SOURCE_SELECT;
      o_dco_range_status          <= `RST_DCO_RANGE;
      o_lock                      <= 1'b0;
      o_mode                      <= 4'h0;
      o_fll_enable                <= 1'b0;
      o_pll_enable                <= 1'b0;
      o_main_from_pll             <= 1'b0;
      o_local_debug_clock_en      <= 1'b0;
      o_debug_clock_open_loop     <= 1'b0;
      o_internal_ref_clock_out_en <= 1'b0;
      o_external_ref_clock_out_en <= 1'b0;
      o_main_clock_gate           <= 1'b0;
    end else begin
      o_reference_status     <= ref_r;
      o_output_source_status <= src_r;
      o_mode                 <= mode_r;
      o_lock <= !i_stop && !lk.running && (dco_cnt_r == 8'h00) &&
                (o_fll_enable || o_pll_enable);
      case (mode_r)
        clkgen_pkg::PLL_ENGAGED_EXTERNAL, clkgen_pkg::PLL_BYPASSED_EXTERNAL,
        clkgen_pkg::LOWPOWER_BYPASS_INTERNAL, clkgen_pkg::LOWPOWER_BYPASS_EXTERNAL:
          o_dco_range_status <= 2'h0;
        default:
          o_dco_range_status <= drs_done_r;
      endcase
      case (mode_r)
        clkgen_pkg::PLL_ENGAGED_EXTERNAL, clkgen_pkg::PLL_BYPASSED_EXTERNAL: begin
          o_pll_enable            <= !i_stop;
          o_fll_enable            <= 1'b0;
          o_local_debug_clock_en  <= !i_stop && i_debug_interface_enabled;
          o_debug_clock_open_loop <= !i_stop && i_debug_interface_enabled;
        end
        clkgen_pkg::LOWPOWER_BYPASS_INTERNAL, clkgen_pkg::LOWPOWER_BYPASS_EXTERNAL: begin
          o_pll_enable            <= 1'b0;
          o_fll_enable            <= 1'b0;
          o_local_debug_clock_en  <= 1'b0;
          o_debug_clock_open_loop <= 1'b0;
        end
        default: begin
          o_pll_enable            <= 1'b0;
          o_fll_enable            <= !i_stop;
          o_local_debug_clock_en  <= !i_stop;
          o_debug_clock_open_loop <= 1'b0;
        end
      endcase
      o_main_from_pll   <= (mode_r == clkgen_pkg::PLL_ENGAGED_EXTERNAL);
      o_main_clock_gate <= !i_stop;
      o_internal_ref_clock_out_en <= i_internal_ref_out_enable &&
                                     (!i_stop || i_internal_ref_stop_enable);
      o_external_ref_clock_out_en <= i_external_ref_out_enable &&
                                     (!i_stop || i_external_ref_stop_enable);
    end
  end

  AST_STOP_LOOPS_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_stop |=> !o_fll_enable && !o_pll_enable && !o_main_clock_gate)
    else $error("Loop running in stop");
  AST_IREF_STOP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_stop && !(i_internal_ref_out_enable && i_internal_ref_stop_enable)
      |=> !o_internal_ref_clock_out_en)
    else $error("Internal ref out active in stop");
  AST_EREF_STOP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_stop && i_external_ref_out_enable && i_external_ref_stop_enable
      |=> o_external_ref_clock_out_en)
    else $error("External ref out lost in stop");
  AST_DCO_RANGE_STATUS_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (mode_r == clkgen_pkg::PLL_ENGAGED_EXTERNAL ||
     mode_r == clkgen_pkg::LOWPOWER_BYPASS_INTERNAL) |=> o_dco_range_status == 2'h0)
    else $error("Range status not zero");
  AST_REF_STATUS_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    ref_switching && ref_cnt_r != 8'h01 |=> ref_r == $past(ref_r))
    else $error("Reference status changed early");
  AST_SRC_UNAVAIL: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    src_cnt_r == 8'h01 && !src_ok |=> src_r == $past(src_r))
    else $error("Unavailable source taken");
  AST_DRS_FROZEN: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_loop_low_power |=> drs_r == $past(drs_r))
    else $error("Range changed under low power");
  AST_PEE_FROM_PLL: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    mode_r == clkgen_pkg::PLL_ENGAGED_EXTERNAL |=> o_main_from_pll)
    else $error("PLL engaged without PLL output");
  AST_LOWPOWER_BYPASS_INTERNAL_EXIT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    mode_r == clkgen_pkg::LOWPOWER_BYPASS_INTERNAL |=> (mode_r ==
      clkgen_pkg::LOWPOWER_BYPASS_INTERNAL || mode_r == clkgen_pkg::FLL_BYPASSED_INTERNAL))
    else $error("Illegal exit from internal low power");
  AST_DCO_UNLOCK: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    dco_done |=> ##1 !o_lock [*8])
    else $error("Lock reported during startup");
  AST_DCO_RANGE_STATUS_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    dco_cnt_r > 8'h01 |=> drs_done_r == $past(drs_done_r))
    else $error("Range status moved before oscillator start");
  AST_RELOCK: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    ref_done && (mode_r == clkgen_pkg::FLL_ENGAGED_INTERNAL ||
                 mode_r == clkgen_pkg::FLL_ENGAGED_EXTERNAL ||
                 mode_r == clkgen_pkg::PLL_ENGAGED_EXTERNAL) |=> lk.running)
    else $error("Loop lock not restarted after reference switch");

  COV_PEE: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    mode_r == clkgen_pkg::PLL_ENGAGED_EXTERNAL);
  COV_LOWPOWER_BYPASS_INTERNAL_TO_FBI: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    mode_r == clkgen_pkg::LOWPOWER_BYPASS_INTERNAL ##1
    mode_r == clkgen_pkg::FLL_BYPASSED_INTERNAL);
  COV_REF_SWITCH: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    ref_done);
  COV_STOP_IREF: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_stop && o_internal_ref_clock_out_en);
endmodule
`default_nettype wire

// ==== clkgen_pkg.sv ====
// Types for the clock generator mode controller
`default_nettype none
package clkgen_pkg;
  typedef enum logic [3:0] {
    FLL_ENGAGED_INTERNAL     = 4'h0,
    FLL_ENGAGED_EXTERNAL     = 4'h1,
    FLL_BYPASSED_INTERNAL    = 4'h2,
    FLL_BYPASSED_EXTERNAL    = 4'h3,
    PLL_ENGAGED_EXTERNAL     = 4'h4,
    PLL_BYPASSED_EXTERNAL    = 4'h5,
    LOWPOWER_BYPASS_INTERNAL = 4'h6,
    LOWPOWER_BYPASS_EXTERNAL = 4'h7
  } mode_type;
endpackage
`default_nettype wire

// ==== clock_generator_mode_control_test.sv ====
// Self-checking bench of the clock generator mode controller
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module clock_generator_mode_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic ref_s; logic [1:0] src; logic pll; logic lp; logic dbg;
    logic [3:0] mode; logic fll; logic pll_en; logic from_pll; logic dclk;
  } row_type;
  logic       clk, rstn, ref_s, pll, lp, dbg, stop, ie, is, ee, es, osc_en, ready;
  logic [1:0] src, dco_range_select, src_st, drs_st;
  logic [3:0] mode;
  logic       ref_st, lock, fll_en, pll_en, from_pll, dclk, open_loop, iref_o, eref_o, gate;
  int         fail_count, cmp_count, cycles, n;
  row_type    rows[11];
  clkgen_mode_ctrl #(.REF_TICK_DIV(2)) u_dut (
    .i_sys_clk(clk), .i_rstn(rstn), .i_reference_select(ref_s),
    .i_output_source_select(src), .i_pll_select(pll), .i_loop_low_power(lp),
    .i_dco_range_select(dco_range_select), .i_debug_interface_enabled(dbg), .i_stop(stop),
    .i_internal_ref_out_enable(ie), .i_internal_ref_stop_enable(is),
    .i_external_ref_out_enable(ee), .i_external_ref_stop_enable(es),
    .i_external_ref_ready(ready), .o_reference_status(ref_st),
    .o_output_source_status(src_st), .o_dco_range_status(drs_st), .o_lock(lock),
    .o_mode(mode), .o_fll_enable(fll_en), .o_pll_enable(pll_en),
    .o_main_from_pll(from_pll), .o_local_debug_clock_en(dclk),
    .o_debug_clock_open_loop(open_loop), .o_internal_ref_clock_out_en(iref_o),
    .o_external_ref_clock_out_en(eref_o), .o_main_clock_gate(gate));
  ext_ref_source u_crystal_oscillator (.i_sys_clk(clk), .i_rstn(rstn), .i_osc_enable(osc_en),
    .o_ready(ready));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wait_mode(input logic [3:0] m);
    n = 0;
    while (mode !== m && n < 100) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
  endtask
  task automatic wait_lock();
    n = 0;
    while (lock !== 1'h1 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask
  initial begin
    rows = '{
      '{1'h1, 2'h1, 1'h0, 1'h0, 1'h0, 4'h2, 1'h1, 1'h0, 1'h0, 1'h1},
      '{1'h1, 2'h1, 1'h0, 1'h1, 1'h0, 4'h6, 1'h0, 1'h0, 1'h0, 1'h0},
      '{1'h1, 2'h1, 1'h0, 1'h1, 1'h1, 4'h2, 1'h1, 1'h0, 1'h0, 1'h1},
      '{1'h1, 2'h1, 1'h0, 1'h0, 1'h0, 4'h2, 1'h1, 1'h0, 1'h0, 1'h1},
      '{1'h0, 2'h2, 1'h0, 1'h0, 1'h0, 4'h3, 1'h1, 1'h0, 1'h0, 1'h1},
      '{1'h0, 2'h2, 1'h1, 1'h0, 1'h0, 4'h5, 1'h0, 1'h1, 1'h0, 1'h0},
      '{1'h0, 2'h0, 1'h1, 1'h0, 1'h0, 4'h4, 1'h0, 1'h1, 1'h1, 1'h0},
      '{1'h0, 2'h0, 1'h1, 1'h0, 1'h1, 4'h4, 1'h0, 1'h1, 1'h1, 1'h1},
      '{1'h0, 2'h2, 1'h1, 1'h0, 1'h0, 4'h5, 1'h0, 1'h1, 1'h0, 1'h0},
      '{1'h0, 2'h2, 1'h1, 1'h1, 1'h0, 4'h7, 1'h0, 1'h0, 1'h0, 1'h0},
      '{1'h0, 2'h2, 1'h1, 1'h1, 1'h1, 4'h5, 1'h0, 1'h1, 1'h0, 1'h1}};
    {rstn, pll, lp, dbg, stop, ie, is, ee, es} = 9'h0;
    {ref_s, osc_en, src, dco_range_select, fail_count, cmp_count, cycles} = '0;
    ref_s = 1'h1;
    osc_en = 1'h1;
    repeat (6) @(negedge clk);
    `CHK("ref_status_rst", 1'h1, ref_st)
    `CHK("mode_rst", 4'(clkgen_pkg::FLL_ENGAGED_INTERNAL), mode)
    `CHK("src_status_rst", 2'h0, src_st)
    rstn = 1'h1;
    repeat (2) @(negedge clk);
    foreach (rows[i]) begin
      {ref_s, src, pll, lp, dbg} = {rows[i].ref_s, rows[i].src, rows[i].pll, rows[i].lp,
                                    rows[i].dbg};
      wait_mode(rows[i].mode);
      `CHK("mode", rows[i].mode, mode)
      `CHK("ref_status", rows[i].ref_s, ref_st)
      `CHK("src_status", rows[i].src, src_st)
      `CHK("pll_en", rows[i].pll_en, pll_en)
      `CHK("from_pll", rows[i].from_pll, from_pll)
      `CHK("dbg_clk", rows[i].dclk, dclk)
      `CHK("open_loop", rows[i].dclk & rows[i].pll, open_loop)
      if (!(rows[i].dbg && rows[i].pll)) `CHK("fll_en", rows[i].fll, fll_en)
      if (rows[i].mode >= 4'h4) `CHK("drs_status", 2'h0, drs_st)
    end
    dbg = 1'h0;
    wait_mode(4'h7);
    src = 2'h0;
    repeat (30) @(negedge clk);
    `CHK("mode_refused", 4'h7, mode)
    src = 2'h3;
    repeat (30) @(negedge clk);
    `CHK("src_reserved", 2'h0, src_st)
    src = 2'h2;
    lp = 1'h0;
    wait_mode(4'h5);
    pll = 1'h0;
    wait_mode(4'h3);
    src = 2'h0;
    wait_mode(4'h1);
    `CHK("mode_fee", 4'h1, mode)
    osc_en = 1'h0;
    src = 2'h2;
    repeat (30) @(negedge clk);
    `CHK("src_not_ready", 2'h0, src_st)
    `CHK("mode_not_ready", 4'h1, mode)
    osc_en = 1'h1;
    wait_mode(4'h3);
    `CHK("src_ready", 2'h2, src_st)
    src = 2'h0;
    wait_mode(4'h1);
    wait_lock();
    `CHK("lock_fee", 1'h1, lock)
    dco_range_select = 2'h2;
    repeat (8) @(negedge clk);
    `CHK("drs_pending", 2'h0, drs_st)
    n = 0;
    while (drs_st !== 2'h2 && n < 60) begin
      @(negedge clk);
      n++;
    end
    `CHK("drs_done", 2'h2, drs_st)
    wait_lock();
    `CHK("lock_drs", 1'h1, lock)
    ref_s = 1'h1;
    wait_mode(4'h0);
    `CHK("lock_restart", 1'h0, lock)
    for (int k = 0; k < 16; k++) begin
      {ie, is, ee, es} = 4'(k);
      stop = 1'h1;
      repeat (4) @(negedge clk);
      `CHK("stop_fll", 1'h0, fll_en)
      `CHK("stop_pll", 1'h0, pll_en)
      `CHK("stop_gate", 1'h0, gate)
      `CHK("stop_iref", ie & is, iref_o)
      `CHK("stop_eref", ee & es, eref_o)
      stop = 1'h0;
      repeat (4) @(negedge clk);
      `CHK("run_gate", 1'h1, gate)
    end
    rstn = 1'h0;
    @(negedge clk);
    `CHK("mode_mid_rst", 4'h0, mode)
    `CHK("ref_mid_rst", 1'h1, ref_st)
    `CHK("lock_mid_rst", 1'h0, lock)
    rstn = 1'h1;
    repeat (2) @(negedge clk);
    `CHK("mode_after_rst", 4'h0, mode)
    end_of_test();
  end
endmodule
`undef CHK
`default_nettype wire

// ==== ext_ref_source.sv ====
// Behavioural external reference source with start-up delay
`default_nettype none
module ext_ref_source #(
  parameter int START_CYCLES = 12
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  input  wire logic i_osc_enable,
  output logic      o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned count_r;
  // Ready only after a full start-up with the oscillator on
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_r <= 0;
    end else if (!i_osc_enable) begin
      count_r <= 0;
    end else if (count_r < START_CYCLES) begin
      count_r <= count_r + 1;
    end
  end
  assign o_ready = (count_r >= START_CYCLES);
endmodule
`default_nettype wire
